// ---- wps_pkg.sv ----
/*
 * Weld pulse supervisor constants, encodings and structs.
 * Assumes one 100 MHz clock.
 */
package wps_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_HZ = 100_000_000;
    localparam int SAMPLE_HZ = 100_000;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int PULSE_TIMEOUT_MS = 200;
    localparam int PULSE_TIMEOUT_CYC = PULSE_TIMEOUT_MS * (CLK_HZ / 1000);
    localparam int SHOW_DELAY_MS = 1000;
    localparam int SHOW_DELAY_CYC = SHOW_DELAY_MS * (CLK_HZ / 1000);
    localparam int SCREEN_MS = 1500;
    localparam int SCREEN_CYC = SCREEN_MS * (CLK_HZ / 1000);
    localparam int TONE_MS = 100;
    localparam int TONE_CYC = TONE_MS * (CLK_HZ / 1000);

    ////////////////////////////////////////////////////////////////////////
    // Electrical limits
    localparam logic [15:0] INPUT_OV_MV = 16'h9C40;   // 40 V
    localparam logic [19:0] SPOT_OV_MV = 20'h09C40;   // 40 V
    localparam logic [11:0] OC_MAX_A = 12'h7D0;       // 2000 A
    localparam logic [11:0] OC_MIN_A = 12'h1F4;       // Floor of derated limit
    localparam logic [11:0] OC_DERATE_A_PER_DM = 12'h00A;
    localparam logic [7:0] OVERTEMP_C = 8'h46;        // 70 degC
    localparam logic [7:0] SPOT_R_MAX_MOHM = 8'h64;   // 100 milliohm
    localparam logic [27:0] UOHM_PER_MOHM = 28'h00003E8;
    // mW x 10 us sums per joule
    localparam logic [39:0] ACC_PER_J = 40'h0005F5E100;
    localparam logic [7:0] CMD_J_RESET = 8'h32;
    localparam logic [7:0] CMD_J_MAX = 8'hFA;

    ////////////////////////////////////////////////////////////////////////
    // Encodings
    typedef enum logic [2:0] {
        ST_VERSION = 3'h0,
        ST_VOLTAGE = 3'h1,
        ST_MODE = 3'h3,
        ST_CONTACT = 3'h2,
        ST_ARMED = 3'h6,
        ST_PULSE = 3'h7,
        ST_RESULT = 3'h5,
        ST_UNCAL = 3'h4
    } wps_state_e;

    typedef enum logic [3:0] {
        SCR_VERSION = 4'h0,
        SCR_VOLTAGE = 4'h1,
        SCR_MODE = 4'h2,
        SCR_CONTACT = 4'h3,
        SCR_UNCAL = 4'h4,
        SCR_ARMED = 4'h5,
        SCR_LOW_BATT = 4'h6,
        SCR_FUSE = 4'h7,
        SCR_OVERTEMP = 4'h8,
        SCR_PULSE = 4'h9,
        SCR_RESULT = 4'hA
    } wps_screen_e;

    typedef enum logic [3:0] {
        STS_OK = 4'h0,
        STS_TIMEOUT = 4'h1,
        STS_INPUT_OV = 4'h2,
        STS_SPOT_NEG = 4'h3,
        STS_SPOT_OV = 4'h4,
        STS_OVERCURR = 4'h5,
        STS_VCC_LOW = 4'h6,
        STS_SPOT_R = 4'h7
    } wps_status_e;

    typedef enum logic [1:0] {
        TONE_OFF = 2'h0,
        TONE_BEEP = 2'h1,
        TONE_HIGH = 2'h2,
        TONE_LOW = 2'h3
    } wps_tone_e;

    typedef struct packed {
        logic [15:0] v_in_mv; // Input supply
        logic [15:0] v_term_mv; // Terminal voltage
        logic [11:0] i_a; // Weld current
        logic [7:0] temp_c; // Switch temperature
        logic vcc_ok; // Supply holds switch on
        logic fuse_ok; // Fuse intact
        logic contact; // Electrodes touch
    } wps_meas_s;

    typedef struct packed {
        logic cal_valid; // Calibration data stored
        logic [15:0] cable_res_uohm;
        logic [7:0] cable_len_dm;
        logic batt_warn_en;
        logic [15:0] batt_warn_mv;
    } wps_cfg_s;

endpackage

// ---- wps_tick.sv ----
/*
 * Divider: one-cycle enable every DIV clocks.
 * Assumes one clock, synchronous reset.
 */
`timescale 1ns/100ps
module wps_tick #(
    parameter int DIV = 1000
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Enable pulse
    output logic tick_out
);
    logic [15:0] cnt_r, cnt_nxt;
    logic tick_nxt;

    // Wrap at DIV-1
    always_comb begin
        tick_nxt = (cnt_r == 16'(DIV - 1));
        cnt_nxt = tick_nxt ? 16'h0000 : cnt_r + 16'h0001;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cnt_r <= 16'h0000;
            tick_out <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_out <= tick_nxt;
        end
    end
endmodule

// ---- wps_energy.sv ----
/*
 * Spot voltage and energy sum, updated on each sample enable.
 * Assumes measurements on the same clock.
 */
`timescale 1ns/100ps
module wps_energy
    import wps_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Control
    input wire logic clear_in,
    input wire logic sample_in,
    // Measurements
    input wire logic [15:0] v_term_mv_in,
    input wire logic [11:0] i_a_in,
    input wire logic [15:0] cable_res_uohm_in,
    // Results
    output logic signed [19:0] v_spot_out,
    output logic [39:0] acc_out,
    output logic valid_out
);
    logic [27:0] drop_prod;
    logic [27:0] drop_mv;
    logic signed [19:0] v_spot_nxt;
    logic [30:0] power_mw;
    logic [39:0] acc_nxt;

    // Spot power = terminal power - cable loss
    always_comb begin
        drop_prod = 28'(i_a_in) * 28'(cable_res_uohm_in);
        drop_mv = drop_prod / UOHM_PER_MOHM;
        v_spot_nxt = $signed({4'h0, v_term_mv_in}) - $signed({1'b0, drop_mv[18:0]});
        power_mw = v_spot_nxt[19] ? 31'h0 : 31'(v_spot_nxt[18:0]) * 31'(i_a_in);
        acc_nxt = acc_out;
        if (clear_in) begin
            acc_nxt = 40'h0;
        end else if (sample_in) begin
            acc_nxt = acc_out + 40'(power_mw);
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            v_spot_out <= 20'sh0;
            acc_out <= 40'h0;
            valid_out <= 1'b0;
        end else begin
            v_spot_out <= sample_in ? v_spot_nxt : v_spot_out;
            acc_out <= acc_nxt;
            valid_out <= sample_in && !clear_in;
        end
    end
endmodule

// ---- wps_top.sv ----
/*
 * Weld pulse supervisor: startup, trigger, pulse aborts,
 * status, tones and result screens.
 * Assumes one clock; foot and dial pins asynchronous,
 * measurements and configuration on the same clock.
 */
// Function
// - End pulse after 200 ms, report timeout
// - Input above 40 V aborts pulse
// - Negative computed spot voltage aborts pulse
// - Spot voltage above 40 V aborts pulse
// - Current above 2000 A or cable limit aborts
// - Collapsed internal supply aborts pulse
// - Spot resistance above 100 milliohm flagged
// - Above 70 degC shows warning, refuses trigger
// - Foot switch at power-up selects mode
// - Show version, voltage, then mode
// - Hold startup while electrodes touch
// - Uncalibrated state forbids weld pulses
// - Armed and foot pressed triggers pulse
// - Dial sets joules; stop when delivered
// - Beep on success, high-low on failure
// - Cycle result screens while trigger held
// - Release clears results, returns to armed
// - Longer cable lowers current limit
// - Blown fuse shows fault instead of armed
// - Enabled low battery level shows warning
// - Dim backlight during pulse
// - Sample power at 100 kHz
`timescale 1ns/100ps
module wps_top
    import wps_pkg::*;
#(
    parameter int TIMEOUT_CYC = PULSE_TIMEOUT_CYC,
    parameter int SHOW_CYC = SHOW_DELAY_CYC,
    parameter int PAGE_CYC = SCREEN_CYC,
    parameter int BEEP_CYC = TONE_CYC,
    parameter int RESULT_PAGES = 3
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Operator pins
    input wire logic foot_sw_in,
    input wire logic dial_up_in,
    input wire logic dial_dn_in,
    // Measurements and configuration
    input wire wps_meas_s meas_in,
    input wire wps_cfg_s cfg_in,
    // Power stage
    output logic switch_on_out,
    output logic backlight_dim_out,
    // Operator feedback
    output wps_screen_e screen_out,
    output logic [1:0] page_out,
    output wps_status_e status_out,
    output logic result_ok_out,
    output wps_tone_e tone_out,
    output logic mode_auto_out,
    output logic [7:0] cmd_j_out,
    output logic [39:0] energy_out
);

    ////////////////////////////////////////////////////////////////////////
    // Current limit falls with cable length
    function automatic logic [11:0] oc_limit(input logic [7:0] len_dm);
        logic [19:0] derate;
        derate = 20'(len_dm) * 20'(OC_DERATE_A_PER_DM);
        if (derate >= 20'(OC_MAX_A - OC_MIN_A)) begin
            return OC_MIN_A;
        end
        return OC_MAX_A - derate[11:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; third dial stage for edges
    logic [1:0] foot_sync_r;
    logic [2:0] up_sync_r, dn_sync_r;
    logic foot_s, up_step, dn_step;

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            foot_sync_r <= 2'h0;
            up_sync_r <= 3'h0;
            dn_sync_r <= 3'h0;
        end else begin
            foot_sync_r <= {foot_sync_r[0], foot_sw_in};
            up_sync_r <= {up_sync_r[1:0], dial_up_in};
            dn_sync_r <= {dn_sync_r[1:0], dial_dn_in};
        end
    end

    assign foot_s = foot_sync_r[1];
    assign up_step = up_sync_r[1] && !up_sync_r[2];
    assign dn_step = dn_sync_r[1] && !dn_sync_r[2];

    ////////////////////////////////////////////////////////////////////////
    // Sampling and energy
    logic sample_en;
    logic acc_clear;
    logic signed [19:0] v_spot;
    logic [39:0] acc;
    logic acc_valid;

    wps_tick #(
        .DIV(SAMPLE_DIV)
    ) u_tick (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .tick_out(sample_en)
    );

    wps_energy u_energy (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .clear_in(acc_clear),
        .sample_in(sample_en),
        .v_term_mv_in(meas_in.v_term_mv),
        .i_a_in(meas_in.i_a),
        .cable_res_uohm_in(cfg_in.cable_res_uohm),
        .v_spot_out(v_spot),
        .acc_out(acc),
        .valid_out(acc_valid)
    );

    assign energy_out = acc;

    ////////////////////////////////////////////////////////////////////////
    // Main sequencer state
    wps_state_e state_r, state_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic mode_auto_r, mode_auto_nxt;
    logic [7:0] cmd_j_r, cmd_j_nxt;
    wps_status_e status_r, status_nxt;
    logic ok_r, ok_nxt;
    logic spot_r_bad_r, spot_r_bad_nxt;
    logic [1:0] page_r, page_nxt;
    wps_screen_e screen_r, screen_nxt;
    logic switch_r, switch_nxt;
    logic done;
    logic done_fail;
    logic over_temp, fuse_bad, low_batt, input_ov;
    logic [39:0] target;
    logic [19:0] spot_r_lim;

    assign over_temp = meas_in.temp_c > OVERTEMP_C;
    assign fuse_bad = !meas_in.fuse_ok;
    assign low_batt = cfg_in.batt_warn_en && (meas_in.v_in_mv < cfg_in.batt_warn_mv);
    assign input_ov = meas_in.v_in_mv > INPUT_OV_MV;
    assign target = 40'(cmd_j_r) * ACC_PER_J;
    assign spot_r_lim = 20'(meas_in.i_a) * 20'(SPOT_R_MAX_MOHM);

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 32'h1;
        mode_auto_nxt = mode_auto_r;
        cmd_j_nxt = cmd_j_r;
        status_nxt = status_r;
        ok_nxt = ok_r;
        spot_r_bad_nxt = spot_r_bad_r;
        page_nxt = page_r;
        switch_nxt = 1'b0;
        acc_clear = 1'b0;
        done = 1'b0;
        done_fail = 1'b0;
        unique case (state_r)
            ST_VERSION: begin
                if (cnt_r >= 32'(SHOW_CYC - 1)) begin
                    // Switch held as version screen ends
                    mode_auto_nxt = foot_s;
                    state_nxt = ST_VOLTAGE;
                    cnt_nxt = 32'h0;
                end
            end
            ST_VOLTAGE: begin
                if (cnt_r >= 32'(SHOW_CYC - 1)) begin
                    state_nxt = ST_MODE;
                    cnt_nxt = 32'h0;
                end
            end
            ST_MODE: begin
                if (cnt_r >= 32'(SHOW_CYC - 1)) begin
                    cnt_nxt = 32'h0;
                    if (meas_in.contact) begin
                        state_nxt = ST_CONTACT;
                    end else begin
                        state_nxt = cfg_in.cal_valid ? ST_ARMED : ST_UNCAL;
                    end
                end
            end
            ST_CONTACT: begin
                if (!meas_in.contact) begin
                    state_nxt = cfg_in.cal_valid ? ST_ARMED : ST_UNCAL;
                end
            end
            ST_UNCAL: begin
                // Trigger ignored
                if (cfg_in.cal_valid) begin
                    state_nxt = ST_ARMED;
                end
            end
            ST_ARMED: begin
                if (up_step && cmd_j_r < CMD_J_MAX) begin
                    cmd_j_nxt = cmd_j_r + 8'h01;
                end else if (dn_step && cmd_j_r > 8'h01) begin
                    cmd_j_nxt = cmd_j_r - 8'h01;
                end
                // Warnings block the trigger
                if (!cfg_in.cal_valid) begin
                    state_nxt = ST_UNCAL;
                end else if (foot_s && !over_temp && !fuse_bad && !low_batt) begin
                    cnt_nxt = 32'h0;
                    spot_r_bad_nxt = 1'b0;
                    acc_clear = 1'b1;
                    page_nxt = 2'h0;
                    if (input_ov) begin
                        // Over-voltage: switch never closes
                        status_nxt = STS_INPUT_OV;
                        ok_nxt = 1'b0;
                        done = 1'b1;
                        done_fail = 1'b1;
                        state_nxt = ST_RESULT;
                    end else begin
                        status_nxt = STS_OK;
                        switch_nxt = 1'b1;
                        state_nxt = ST_PULSE;
                    end
                end
            end
            ST_PULSE: begin
                switch_nxt = 1'b1;
                // Faults by priority; first one kept
                if (acc_valid) begin
                    if (meas_in.i_a != 12'h0 && v_spot > $signed(spot_r_lim)) begin
                        spot_r_bad_nxt = 1'b1;
                    end
                    if (input_ov) begin
                        status_nxt = STS_INPUT_OV;
                        done_fail = 1'b1;
                    end else if (!meas_in.vcc_ok) begin
                        status_nxt = STS_VCC_LOW;
                        done_fail = 1'b1;
                    end else if (meas_in.i_a > oc_limit(cfg_in.cable_len_dm)) begin
                        status_nxt = STS_OVERCURR;
                        done_fail = 1'b1;
                    end else if (v_spot < 20'sh0) begin
                        status_nxt = STS_SPOT_NEG;
                        done_fail = 1'b1;
                    end else if (v_spot > $signed(SPOT_OV_MV)) begin
                        status_nxt = STS_SPOT_OV;
                        done_fail = 1'b1;
                    end else if (acc >= target) begin
                        // Energy reached
                        status_nxt = spot_r_bad_nxt ? STS_SPOT_R : STS_OK;
                        done_fail = spot_r_bad_nxt;
                        done = 1'b1;
                    end
                end
                if (!done && !done_fail && cnt_r >= 32'(TIMEOUT_CYC - 1)) begin
                    status_nxt = STS_TIMEOUT;
                    done_fail = 1'b1;
                end
                if (done || done_fail) begin
                    done = 1'b1;
                    switch_nxt = 1'b0;
                    ok_nxt = !done_fail;
                    state_nxt = ST_RESULT;
                    cnt_nxt = 32'h0;
                end
            end
            ST_RESULT: begin
                if (!foot_s) begin
                    // Release drops results
                    status_nxt = STS_OK;
                    ok_nxt = 1'b0;
                    page_nxt = 2'h0;
                    state_nxt = ST_ARMED;
                end else if (cnt_r >= 32'(PAGE_CYC - 1)) begin
                    cnt_nxt = 32'h0;
                    page_nxt = (page_r == 2'(RESULT_PAGES - 1)) ? 2'h0 : page_r + 2'h1;
                end
            end
            default: begin
                state_nxt = ST_VERSION;
                cnt_nxt = 32'h0;
            end
        endcase
    end

    // Screen for next state
    always_comb begin
        unique case (state_nxt)
            ST_VERSION: screen_nxt = SCR_VERSION;
            ST_VOLTAGE: screen_nxt = SCR_VOLTAGE;
            ST_MODE: screen_nxt = SCR_MODE;
            ST_CONTACT: screen_nxt = SCR_CONTACT;
            ST_UNCAL: screen_nxt = SCR_UNCAL;
            ST_PULSE: screen_nxt = SCR_PULSE;
            ST_RESULT: screen_nxt = SCR_RESULT;
            ST_ARMED: begin
                if (over_temp) begin
                    screen_nxt = SCR_OVERTEMP;
                end else if (fuse_bad) begin
                    screen_nxt = SCR_FUSE;
                end else if (low_batt) begin
                    screen_nxt = SCR_LOW_BATT;
                end else begin
                    screen_nxt = SCR_ARMED;
                end
            end
            default: screen_nxt = SCR_VERSION;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state_r <= ST_VERSION;
            cnt_r <= 32'h0;
            mode_auto_r <= 1'b0;
            cmd_j_r <= CMD_J_RESET;
            status_r <= STS_OK;
            ok_r <= 1'b0;
            spot_r_bad_r <= 1'b0;
            page_r <= 2'h0;
            screen_r <= SCR_VERSION;
            switch_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            mode_auto_r <= mode_auto_nxt;
            cmd_j_r <= cmd_j_nxt;
            status_r <= status_nxt;
            ok_r <= ok_nxt;
            spot_r_bad_r <= spot_r_bad_nxt;
            page_r <= page_nxt;
            screen_r <= screen_nxt;
            switch_r <= switch_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tone sequencer, apart from screens
    wps_tone_e tone_r, tone_nxt;
    logic [31:0] tone_cnt_r, tone_cnt_nxt;

    always_comb begin
        tone_nxt = tone_r;
        tone_cnt_nxt = tone_cnt_r + 32'h1;
        if (done) begin
            tone_nxt = done_fail ? TONE_HIGH : TONE_BEEP;
            tone_cnt_nxt = 32'h0;
        end else if (tone_r != TONE_OFF && tone_cnt_r >= 32'(BEEP_CYC - 1)) begin
            tone_cnt_nxt = 32'h0;
            tone_nxt = (tone_r == TONE_HIGH) ? TONE_LOW : TONE_OFF;
        end else if (tone_r == TONE_OFF) begin
            tone_cnt_nxt = 32'h0;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            tone_r <= TONE_OFF;
            tone_cnt_r <= 32'h0;
        end else begin
            tone_r <= tone_nxt;
            tone_cnt_r <= tone_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all registered
    assign switch_on_out = switch_r;
    assign backlight_dim_out = switch_r;
    assign screen_out = screen_r;
    assign page_out = page_r;
    assign status_out = status_r;
    assign result_ok_out = ok_r;
    assign tone_out = tone_r;
    assign mode_auto_out = mode_auto_r;
    assign cmd_j_out = cmd_j_r;
endmodule

// ---- wps_checker.sv ----
/* Port checker for wps_top.
   Assumes instance timing parameters. */
`timescale 1ns/100ps
module wps_checker
    import wps_pkg::*;
#(
    parameter int TIMEOUT_CYC = 2000,
    parameter int BEEP_CYC = 10
) (
    // Clock, reset, pin
    input wire logic mclk_in, rst_n_in, foot_sw_in,
    // Inputs
    input wire wps_meas_s meas_in,
    input wire wps_cfg_s cfg_in,
    // Watched outputs
    input wire logic switch_on_out, backlight_dim_out, mode_auto_out,
    input wire wps_screen_e screen_out,
    input wire logic [1:0] page_out,
    input wire wps_status_e status_out,
    input wire wps_tone_e tone_out
);
    localparam int TONE_LIM = BEEP_CYC + 2;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    ////////////////////////////////////////
    // On-time counter
    int on_r, on_nxt;
    always_comb on_nxt = switch_on_out ? on_r + 1 : 0;
    always_ff @(posedge mclk_in) on_r <= rst_n_in ? on_nxt : 0;
    // Pulse end, failure tones
    sequence s_fall; $fell(switch_on_out); endsequence
    sequence s_bad; tone_out == TONE_HIGH ##[1:TONE_LIM] tone_out == TONE_LOW; endsequence
    property p_dim; switch_on_out == backlight_dim_out; endproperty
    a_dim: assert property (p_dim) else $error("dim differs");
    property p_take; $rose(switch_on_out) |-> screen_out == SCR_PULSE && $past(cfg_in.cal_valid)
        && $past(meas_in.fuse_ok) && $past(meas_in.temp_c) <= OVERTEMP_C; endproperty
    a_take: assert property (p_take) else $error("blocked start");
    property p_len; on_r <= TIMEOUT_CYC + 1; endproperty
    a_len: assert property (p_len) else $error("pulse too long");
    property p_ok; s_fall ##0 status_out == STS_OK |-> tone_out == TONE_BEEP; endproperty
    a_ok: assert property (p_ok) else $error("no beep");
    property p_bad; s_fall ##0 status_out != STS_OK |-> s_bad; endproperty
    a_bad: assert property (p_bad) else $error("no fail tones");
    property p_page; screen_out == SCR_RESULT && $past(screen_out) == SCR_RESULT
        && $changed(page_out) |->
        page_out == ($past(page_out) == 2'h2 ? 2'h0 : $past(page_out) + 2'h1); endproperty
    a_page: assert property (p_page) else $error("bad page step");
    property p_rel; screen_out == SCR_RESULT && $fell(foot_sw_in) |->
        ##[1:4] screen_out == SCR_ARMED && status_out == STS_OK && page_out == 2'h0; endproperty
    a_rel: assert property (p_rel) else $error("no rearm");
    property p_mode; screen_out != SCR_VERSION && $past(screen_out) != SCR_VERSION
        |-> $stable(mode_auto_out); endproperty
    a_mode: assert property (p_mode) else $error("mode changed");
endmodule
bind wps_top wps_checker #(.TIMEOUT_CYC(TIMEOUT_CYC), .BEEP_CYC(BEEP_CYC)) u_chk (.*);

// ---- wps_partner.sv ----
/* Supply, converter and switch model.
   Assumes bench values on the same clock. */
`timescale 1ns/100ps
module wps_partner
    import wps_pkg::*;
(
    // Switch and scenario
    input wire logic switch_on_in,
    input wire logic [15:0] v_in_in, v_term_in,
    input wire logic [11:0] i_in,
    input wire logic [7:0] temp_in,
    input wire logic vcc_ok_in, fuse_ok_in, contact_in,
    // Converter outputs
    output wps_meas_s meas_out
);
    // Open switch: no current, dead terminals
    always_comb begin
        meas_out = '{v_in_in, v_term_in, i_in, temp_in, vcc_ok_in, fuse_ok_in, contact_in};
        if (!switch_on_in) begin
            meas_out.v_term_mv = 16'h0000;
            meas_out.i_a = 12'h000;
        end
    end
endmodule

// ---- wps_tb_top.sv ----
/* Bench for wps_top and its far-side model.
   Short timings; inputs change on falling edges. */
`timescale 1ns/100ps
module wps_tb_top;
    import wps_pkg::*;
    // Bench signals
    logic mclk_in = 1'b0, rst_n_in = 1'b0, foot = 1'b0, up = 1'b0, dn = 1'b0;
    logic sw, dim, ok, auto, vcc = 1'b1, fuse = 1'b1, touch = 1'b0;
    logic [15:0] v_in = 16'h2EE0, v_term = 16'h0000;
    logic [11:0] cur = 12'h000;
    logic [7:0] temp = 8'h19, cmd;
    logic [1:0] page;
    logic [39:0] energy;
    wps_cfg_s cfg = '{1'b1, 16'h0000, 8'h00, 1'b0, 16'h32C8};
    wps_meas_s meas;
    wps_screen_e scr;
    wps_status_e sts;
    wps_tone_e tone;
    int err_count = 0, n_tests = 0;
    ////////////////////////////////////////
    // Far side and dut
    wps_partner u_meas (.switch_on_in(sw), .v_in_in(v_in), .v_term_in(v_term), .i_in(cur),
        .temp_in(temp), .vcc_ok_in(vcc), .fuse_ok_in(fuse), .contact_in(touch), .meas_out(meas));
    wps_top #(.TIMEOUT_CYC(10000), .SHOW_CYC(20), .PAGE_CYC(30), .BEEP_CYC(10)) dut (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .foot_sw_in(foot), .dial_up_in(up),
        .dial_dn_in(dn), .meas_in(meas), .cfg_in(cfg), .switch_on_out(sw),
        .backlight_dim_out(dim), .screen_out(scr), .page_out(page), .status_out(sts),
        .result_ok_out(ok), .tone_out(tone), .mode_auto_out(auto), .cmd_j_out(cmd),
        .energy_out(energy));
    // Free-running 100 MHz clock
    initial forever #5 mclk_in = ~mclk_in;
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    // Bounded wait
    task automatic wait_scr(input wps_screen_e s, input int lim);
        while (scr !== s && lim-- > 0) cyc(1);
        chk(scr, s);
    endtask
    task automatic boot(input logic f);
        rst_n_in = 1'b0;
        foot = f;
        cyc(2);
        rst_n_in = 1'b1;
    endtask
    task automatic dial(input logic d, input int n);
        repeat (n) begin
            {up, dn} = {d, !d};
            cyc(3);
            {up, dn} = 2'b00;
            cyc(3);
        end
    endtask
    task automatic t_boot();
        cfg.cal_valid = 1'b0;
        touch = 1'b1;
        boot(1'b0);
        cyc(10);
        chk(scr, SCR_VERSION);
        cyc(20);
        chk(scr, SCR_VOLTAGE);
        cyc(20);
        chk({scr, auto}, {SCR_MODE, 1'b0});
        cyc(50);
        chk(scr, SCR_CONTACT);
        touch = 1'b0;
        wait_scr(SCR_UNCAL, 5);
        foot = 1'b1;
        cyc(10);
        chk(sw, 1'b0);
        foot = 1'b0;
        cyc(4);
        cfg.cal_valid = 1'b1;
        wait_scr(SCR_ARMED, 5);
        boot(1'b1);
        cyc(30);
        foot = 1'b0;
        cyc(40);
        chk({scr, auto}, {SCR_ARMED, 1'b1});
        $display("boot done");
    endtask
    task automatic t_weld();
        dial(1'b0, 50);
        chk(cmd, 8'h01);
        dial(1'b1, 2);
        chk(cmd, 8'h03);
        dial(1'b0, 2);
        v_term = 16'h7530;
        cur = 12'h5DC;
        foot = 1'b1;
        cyc(4);
        chk({sw, dim, scr}, {2'b11, SCR_PULSE});
        wait_scr(SCR_RESULT, 4000);
        chk({sts, ok, tone}, {STS_OK, 1'b1, TONE_BEEP});
        chk(energy, 40'h00080BEFC0);
        cyc(35);
        chk(page, 2'h1);
        cyc(30);
        chk(page, 2'h2);
        foot = 1'b0;
        cyc(5);
        chk({scr, sts, page}, {SCR_ARMED, STS_OK, 2'h0});
        $display("weld done");
    endtask
    task automatic fault(input logic [15:0] vi, vt, input logic [11:0] i,
        input logic [7:0] len, input logic [15:0] res, input logic vok, input wps_status_e e);
        {v_in, v_term, cur, vcc} = {vi, vt, i, vok};
        {cfg.cable_len_dm, cfg.cable_res_uohm} = {len, res};
        foot = 1'b1;
        wait_scr(SCR_RESULT, 12000);
        chk({sts, ok, tone}, {e, 1'b0, TONE_HIGH});
        cyc(12);
        chk(tone, TONE_LOW);
        {foot, v_in, vcc} = {1'b0, 16'h2EE0, 1'b1};
        wait_scr(SCR_ARMED, 8);
    endtask
    task automatic t_faults();
        fault(16'h2EE0, 16'h0000, 12'h000, 8'h00, 16'h0000, 1'b1, STS_TIMEOUT);
        fault(16'h9C41, 16'h7530, 12'h5DC, 8'h00, 16'h0000, 1'b1, STS_INPUT_OV);
        fault(16'h2EE0, 16'h1388, 12'h3E8, 8'h00, 16'h2710, 1'b1, STS_SPOT_NEG);
        fault(16'h2EE0, 16'h9C41, 12'h064, 8'h00, 16'h0000, 1'b1, STS_SPOT_OV);
        fault(16'h2EE0, 16'h7530, 12'h7D1, 8'h00, 16'h0000, 1'b1, STS_OVERCURR);
        fault(16'h2EE0, 16'h7530, 12'h640, 8'h32, 16'h0000, 1'b1, STS_OVERCURR);
        fault(16'h2EE0, 16'h7530, 12'h5DC, 8'h00, 16'h0000, 1'b0, STS_VCC_LOW);
        fault(16'h2EE0, 16'h9C40, 12'h18F, 8'h00, 16'h0000, 1'b1, STS_SPOT_R);
        $display("faults done");
    endtask
    // Warnings hold off trigger
    task automatic blocked(input logic [7:0] t, input logic f, be, input wps_screen_e s);
        {temp, fuse, cfg.batt_warn_en} = {t, f, be};
        wait_scr(s, 5);
        foot = 1'b1;
        cyc(10);
        chk(sw, 1'b0);
        foot = 1'b0;
        cyc(4);
        {temp, fuse, cfg.batt_warn_en} = {8'h19, 1'b1, 1'b0};
        wait_scr(SCR_ARMED, 5);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        t_boot();
        t_weld();
        t_faults();
        blocked(8'h47, 1'b1, 1'b0, SCR_OVERTEMP);
        blocked(8'h19, 1'b0, 1'b0, SCR_FUSE);
        blocked(8'h19, 1'b1, 1'b1, SCR_LOW_BATT);
        $display("warnings done");
        print_verdict();
    end
    // Watchdog
    initial begin
        #1_000_000;
        err_count++;
        print_verdict();
    end
endmodule
